// ---- hw/scodec_decoder.sv ----
/*
  Subtract and control opcode decoder with state-count sequencer.
  Assumes opValid is a one-cycle request, accepted only while idle,
  and flagCond gives the condition test result for two-count opcodes.
*/
`timescale 1ns/1ps
// What this block does
// RULE1: register subtracts decode, four states each
// RULE2: memory and immediate subtracts take seven states
// RULE3: register field B..L, memory, accumulator
// RULE4: two-count opcodes pick by flag test
// RULE5: state period 330 ns (here 17 clocks of 20 ns, so 340 ns)
// RULE6: control opcodes decode with their counts
module scodec_decoder #(
  parameter logic [3:0] COND_SHORT = 4'h6,
  parameter logic [3:0] COND_LONG = 4'hc
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] opcode,
  input wire logic opValid,
  input wire logic condOp,
  input wire logic flagCond,
  output logic busy,
  output logic done,
  output logic known,
  output scodec_pkg::scodec_op_t opKind,
  output scodec_pkg::scodec_src_t srcReg,
  output logic [3:0] stateCount
);
  typedef enum logic [1:0] {SCODEC_IDLE, SCODEC_RUN} scodec_fsm_t;
  typedef struct packed {
    scodec_fsm_t fsm;
    logic [3:0] left;
    logic [3:0] total;
    logic busy;
    logic done;
    logic known;
    scodec_pkg::scodec_op_t kind;
    scodec_pkg::scodec_src_t src;
  } scodec_st_t;
  scodec_st_t st_ff, nxt_st;
  scodec_pkg::scodec_op_t decKind;
  scodec_pkg::scodec_src_t decSrc;
  logic [3:0] decCnt;

  scodec_tick_if tk ();
  scodec_state_timer u_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick(tk)
  );

  function automatic scodec_pkg::scodec_src_t src_of(input logic [2:0] f);
    // RULE3 register field
    case (f)
      3'h0: src_of = scodec_pkg::SCODEC_R_B;
      3'h1: src_of = scodec_pkg::SCODEC_R_C;
      3'h2: src_of = scodec_pkg::SCODEC_R_D;
      3'h3: src_of = scodec_pkg::SCODEC_R_E;
      3'h4: src_of = scodec_pkg::SCODEC_R_H;
      3'h5: src_of = scodec_pkg::SCODEC_R_L;
      scodec_pkg::RegMemCode: src_of = scodec_pkg::SCODEC_R_MEM;
      default: src_of = scodec_pkg::SCODEC_R_ACC;
    endcase
  endfunction

  always_comb begin
    decKind = scodec_pkg::SCODEC_OP_NONE;
    decSrc = scodec_pkg::SCODEC_R_NONE;
    decCnt = scodec_pkg::StatesShort;
    if (opcode[7:3] == scodec_pkg::SubRegPfx ||
        opcode[7:3] == scodec_pkg::SbbRegPfx) begin
      decKind = opcode[3] ? scodec_pkg::SCODEC_OP_SBB
                          : scodec_pkg::SCODEC_OP_SUB;
      decSrc = src_of(opcode[2:0]);
      // RULE1 register form four states
      decCnt = scodec_pkg::StatesShort;
      // RULE2 memory operand adds fetch
      if (opcode == scodec_pkg::SubMemOp || opcode == scodec_pkg::SbbMemOp)
        decCnt = scodec_pkg::StatesMem;
    end else begin
      case (opcode)
        // RULE2 immediate forms
        scodec_pkg::SubImmOp: begin
          decKind = scodec_pkg::SCODEC_OP_SUBI;
          decCnt = scodec_pkg::StatesMem;
        end
        scodec_pkg::SbiImmOp: begin
          decKind = scodec_pkg::SCODEC_OP_SBBI;
          decCnt = scodec_pkg::StatesMem;
        end
        // RULE6 control opcodes
        scodec_pkg::IntEnOp: decKind = scodec_pkg::SCODEC_OP_IEN;
        scodec_pkg::IntDisOp: decKind = scodec_pkg::SCODEC_OP_IDIS;
        scodec_pkg::IdleOp: decKind = scodec_pkg::SCODEC_OP_IDLE;
        scodec_pkg::MaskRdOp: decKind = scodec_pkg::SCODEC_OP_MRD;
        scodec_pkg::MaskWrOp: decKind = scodec_pkg::SCODEC_OP_MWR;
        scodec_pkg::StopOp: begin
          decKind = scodec_pkg::SCODEC_OP_STOP;
          decCnt = scodec_pkg::StatesStop;
        end
        default: begin
          // RULE4 flag-dependent length
          if (condOp)
            decCnt = flagCond ? COND_LONG : COND_SHORT;
        end
      endcase
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.fsm)
      SCODEC_IDLE: begin
        if (opValid) begin
          nxt_st.fsm = SCODEC_RUN;
          nxt_st.busy = 1'b1;
          nxt_st.kind = decKind;
          nxt_st.src = decSrc;
          nxt_st.known = decKind != scodec_pkg::SCODEC_OP_NONE;
          nxt_st.total = decCnt;
          nxt_st.left = decCnt;
        end
      end
      SCODEC_RUN: begin
        // RULE5 one count per state period
        if (tk.stateTick) begin
          nxt_st.left = st_ff.left - 4'h1;
          if (st_ff.left == 4'h1) begin
            nxt_st.fsm = SCODEC_IDLE;
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
          end
        end
      end
      default: nxt_st.fsm = SCODEC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{fsm: SCODEC_IDLE, left: 4'h0, total: 4'h0, busy: 1'b0,
                 done: 1'b0, known: 1'b0,
                 kind: scodec_pkg::SCODEC_OP_NONE,
                 src: scodec_pkg::SCODEC_R_NONE};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
  assign done = st_ff.done;
  assign known = st_ff.known;
  assign opKind = st_ff.kind;
  assign srcReg = st_ff.src;
  assign stateCount = st_ff.total;

  // done shows one cycle after the edge of the last state tick;
  // free running timer makes the first state anywhere from 1 to a full one
  localparam int RunLoShort =
    (scodec_pkg::StatesShort - 1) * scodec_pkg::StateClks + 2;
  localparam int RunHiShort =
    scodec_pkg::StatesShort * scodec_pkg::StateClks + 1;
  localparam int RunLoMem =
    (scodec_pkg::StatesMem - 1) * scodec_pkg::StateClks + 2;
  localparam int RunHiMem =
    scodec_pkg::StatesMem * scodec_pkg::StateClks + 1;

  subRegCount_a: // RULE1
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (!busy && opValid && opcode[7:4] == 4'h9 && opcode[2:0] != 3'h6)
    |=> stateCount == 4'h4 && (opKind == scodec_pkg::SCODEC_OP_SUB ||
                               opKind == scodec_pkg::SCODEC_OP_SBB))
  else $error("register subtract count wrong");

  memImmCount_a: // RULE2
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (!busy && opValid && (opcode == 8'h96 || opcode == 8'h9e ||
                          opcode == 8'hd6 || opcode == 8'hde))
    |=> stateCount == 4'h7)
  else $error("memory or immediate subtract count wrong");

  regField_a: // RULE3
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (!busy && opValid && opcode[7:4] == 4'h9)
    |=> srcReg == scodec_pkg::scodec_src_t'({1'b0, $past(opcode[2:0])}))
  else $error("source register field wrong");

  condCount_a: // RULE4
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (!busy && opValid && condOp && decKind == scodec_pkg::SCODEC_OP_NONE)
    |=> stateCount == ($past(flagCond) ? 4'hc : 4'h6))
  else $error("conditional count does not follow flag");

  stopCount_a: // RULE6
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (!busy && opValid && opcode == 8'h76)
    |=> stateCount == 4'h5 && opKind == scodec_pkg::SCODEC_OP_STOP)
  else $error("stop opcode count wrong");

  ctrlCount_a: // RULE6
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (!busy && opValid && (opcode == 8'hfb || opcode == 8'hf3 ||
                          opcode == 8'h00 || opcode == 8'h20 ||
                          opcode == 8'h30))
    |=> stateCount == 4'h4 && known)
  else $error("control opcode count wrong");

  runLength_a: // RULE5
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (!busy && opValid && decCnt == scodec_pkg::StatesShort)
    |-> ##[RunLoShort:RunHiShort] done)
  else $error("four-state run not near 1.3 us");

  doneEnds_a: // RULE5
  assert property (@(posedge core_clk) disable iff (!arst_n)
    done |-> !busy && $past(busy))
  else $error("done without a finished run");

  memRunLength_a: // RULE2
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (!busy && opValid && decCnt == scodec_pkg::StatesMem)
    |-> ##[RunLoMem:RunHiMem] done)
  else $error("seven-state run length wrong");

  refusedHeld_a: // RULE5
  assert property (@(posedge core_clk) disable iff (!arst_n)
    busy |=> $stable(opKind) && $stable(stateCount) && $stable(srcReg))
  else $error("request taken while busy");

  srcNone_a: // RULE3
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (!busy && opValid && decKind != scodec_pkg::SCODEC_OP_SUB &&
     decKind != scodec_pkg::SCODEC_OP_SBB)
    |=> srcReg == scodec_pkg::SCODEC_R_NONE)
  else $error("source register given for non-subtract");
endmodule // scodec_decoder

// ---- hw/scodec_state_timer.sv ----
/*
  State timer: one-cycle pulse each processor state period.
  Assumes core_clk at the rate named in the package.
*/
`timescale 1ns/1ps
module scodec_state_timer #(
  parameter int unsigned DIV = scodec_pkg::StateClks
) (
  input wire logic core_clk,
  input wire logic arst_n,
  scodec_tick_if.timer tick
);
  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } scodec_tmr_t;
  scodec_tmr_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    // RULE5 state period
    if (st_ff.cnt == 5'(DIV - 1)) begin
      nxt_st.cnt = 5'h0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 5'h1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick.stateTick = st_ff.tick;

  periodTick_a: // RULE5
  assert property (@(posedge core_clk) disable iff (!arst_n)
    st_ff.tick |=> !st_ff.tick)
  else $error("state tick longer than one cycle");
endmodule // scodec_state_timer

// ---- include/scodec_pkg.sv ----
/*
  Constants for the subtract/control opcode decoder: opcode patterns,
  register field codes, state counts and state period.
  Assumes an 8-bit opcode and a core clock of 50 MHz.
*/
package scodec_pkg;
  localparam int unsigned ClkPeriodNs = 20;
  localparam int unsigned StatePeriodNs = 330;
  // least time, rounded up to whole clocks
  localparam int unsigned StateClks =
    (StatePeriodNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int unsigned StateCntW = 5;

  localparam logic [4:0] SubRegPfx = 5'h12;
  localparam logic [4:0] SbbRegPfx = 5'h13;
  localparam logic [7:0] SubMemOp = 8'h96;
  localparam logic [7:0] SbbMemOp = 8'h9e;
  localparam logic [7:0] SubImmOp = 8'hd6;
  localparam logic [7:0] SbiImmOp = 8'hde;
  localparam logic [7:0] IntEnOp = 8'hfb;
  localparam logic [7:0] IntDisOp = 8'hf3;
  localparam logic [7:0] IdleOp = 8'h00;
  localparam logic [7:0] MaskRdOp = 8'h20;
  localparam logic [7:0] MaskWrOp = 8'h30;
  localparam logic [7:0] StopOp = 8'h76;

  localparam logic [2:0] RegMemCode = 3'h6;
  localparam logic [2:0] RegAccCode = 3'h7;

  localparam logic [3:0] StatesShort = 4'h4;
  localparam logic [3:0] StatesStop = 4'h5;
  localparam logic [3:0] StatesMem = 4'h7;

  typedef enum logic [3:0] {
    SCODEC_OP_NONE, SCODEC_OP_SUB, SCODEC_OP_SBB, SCODEC_OP_SUBI,
    SCODEC_OP_SBBI, SCODEC_OP_IEN, SCODEC_OP_IDIS, SCODEC_OP_IDLE,
    SCODEC_OP_MRD, SCODEC_OP_MWR, SCODEC_OP_STOP
  } scodec_op_t;

  typedef enum logic [3:0] {
    SCODEC_R_B, SCODEC_R_C, SCODEC_R_D, SCODEC_R_E, SCODEC_R_H,
    SCODEC_R_L, SCODEC_R_MEM, SCODEC_R_ACC, SCODEC_R_NONE
  } scodec_src_t;
endpackage

// ---- include/scodec_tick_if.sv ----
/*
  Carrier between the decoder and its state timer.
  Assumes both ends share core_clk.
*/
`timescale 1ns/1ps
interface scodec_tick_if;
  logic stateTick;
  modport timer (output stateTick);
  modport user (input stateTick);
endinterface

// ---- verif/scodec_seq_model.sv ----
/*
  Sequencer stand-in: counts the busy cycles of each instruction.
  Assumes busy and done come from the decoder on core_clk.
*/
`timescale 1ns/1ps
module scodec_seq_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic busy,
  input wire logic done,
  output logic [8:0] busyLen
);
  typedef struct packed {
    logic [8:0] cnt;
  } scodec_seq_t;
  scodec_seq_t st_ff;
  scodec_seq_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (busy) begin
      nxt_st.cnt = st_ff.cnt + 9'h1;
    end
    if (done) begin
      nxt_st.cnt = 9'h0;
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign busyLen = st_ff.cnt;
endmodule // scodec_seq_model

// ---- verif/tb_subtract_control_opcode_decoder.sv ----
/*
  Self-checking bench for the opcode decoder, fixed-seed random stimulus.
  Assumes the decoder holds its own state timer.
*/
`timescale 1ns/1ps
module tb_subtract_control_opcode_decoder;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic opValid = 1'b0;
  logic condOp = 1'b0;
  logic flagCond = 1'b0;
  logic busy, done, known;
  scodec_pkg::scodec_op_t opKind;
  scodec_pkg::scodec_src_t srcReg;
  logic [3:0] stateCount;
  logic [8:0] busyLen;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int i, k;
  logic [7:0] ops [9] = '{8'hfb, 8'hf3, 8'h00, 8'h20, 8'h30, 8'h76,
    8'h9e, 8'hd6, 8'hde};

  scodec_decoder u_scodec_decoder (.core_clk(core_clk), .arst_n(arst_n),
    .opcode(opcode), .opValid(opValid), .condOp(condOp),
    .flagCond(flagCond), .busy(busy), .done(done), .known(known),
    .opKind(opKind), .srcReg(srcReg), .stateCount(stateCount));
  scodec_seq_model u_scodec_seq_model (.core_clk(core_clk),
    .arst_n(arst_n), .busy(busy), .done(done), .busyLen(busyLen));

  initial forever #10 core_clk = ~core_clk;

  // {known, kind, states}
  function automatic logic [8:0] expect_of(logic [7:0] op, logic c,
      logic f);
    logic [3:0] kd;
    logic [3:0] n;
    kd = scodec_pkg::SCODEC_OP_NONE;
    if (op[7:3] == 5'h12) kd = scodec_pkg::SCODEC_OP_SUB;
    if (op[7:3] == 5'h13) kd = scodec_pkg::SCODEC_OP_SBB;
    case (op)
      8'hd6: kd = scodec_pkg::SCODEC_OP_SUBI;
      8'hde: kd = scodec_pkg::SCODEC_OP_SBBI;
      8'hfb: kd = scodec_pkg::SCODEC_OP_IEN;
      8'hf3: kd = scodec_pkg::SCODEC_OP_IDIS;
      8'h00: kd = scodec_pkg::SCODEC_OP_IDLE;
      8'h20: kd = scodec_pkg::SCODEC_OP_MRD;
      8'h30: kd = scodec_pkg::SCODEC_OP_MWR;
      8'h76: kd = scodec_pkg::SCODEC_OP_STOP;
      default: ;
    endcase
    n = 4'h4;
    if (kd == scodec_pkg::SCODEC_OP_STOP) n = 4'h5;
    if (kd inside {scodec_pkg::SCODEC_OP_SUBI, scodec_pkg::SCODEC_OP_SBBI})
      n = 4'h7;
    if (kd inside {scodec_pkg::SCODEC_OP_SUB, scodec_pkg::SCODEC_OP_SBB}
        && op[2:0] == 3'h6) n = 4'h7;
    if (kd == scodec_pkg::SCODEC_OP_NONE && c) n = f ? 4'hc : 4'h6;
    return {kd != scodec_pkg::SCODEC_OP_NONE, kd, n};
  endfunction

  task automatic cmp(string nm, logic [3:0] e, logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_len(logic [8:0] g, logic [3:0] n);
    int lo, hi;
    lo = (n - 1) * scodec_pkg::StateClks + 1;
    hi = n * scodec_pkg::StateClks;
    n_compared++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_errors++;
      $display("[FAIL] busyLen expected %0d..%0d seen %0d", lo, hi, g);
    end
  endtask

  task automatic chk_reset();
    cmp("busy", 4'h0, {3'h0, busy});
    cmp("opKind", 4'h0, opKind);
    cmp("srcReg", 4'h8, srcReg);
    cmp("stateCount", 4'h0, stateCount);
    cmp("known", 4'h0, {3'h0, known});
    cmp("done", 4'h0, {3'h0, done});
  endtask

  task automatic send(logic [7:0] op, logic c, logic f);
    logic [8:0] e;
    int w;
    e = expect_of(op, c, f);
    opcode = op;
    condOp = c;
    flagCond = f;
    opValid = 1'b1;
    @(posedge core_clk);
    #1;
    cmp("busy", 4'h1, {3'h0, busy});
    cmp("known", {3'h0, e[8]}, {3'h0, known});
    cmp("opKind", e[7:4], opKind);
    cmp("stateCount", e[3:0], stateCount);
    if (e[7:4] inside {scodec_pkg::SCODEC_OP_SUB, scodec_pkg::SCODEC_OP_SBB})
      cmp("srcReg", {1'b0, op[2:0]}, srcReg);
    else
      cmp("srcReg", scodec_pkg::SCODEC_R_NONE, srcReg);
    // request held while busy must be refused
    opcode = ~op;
    @(posedge core_clk);
    #1;
    opValid = 1'b0;
    cmp("opKind held", e[7:4], opKind);
    w = 0;
    while (done !== 1'b1 && w < 300) begin
      @(posedge core_clk);
      #1;
      w++;
    end
    cmp("done", 4'h1, {3'h0, done});
    cmp("busy", 4'h0, {3'h0, busy});
    cmp_len(busyLen, e[3:0]);
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 40000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    k = $urandom(32'h276231d0);
    repeat (2) @(posedge core_clk);
    #1;
    chk_reset();
    arst_n = 1'b1;
    for (i = 0; i < 16; i++) send(8'h90 + 8'(i), 1'b0, 1'b0);
    $display("test register subtracts ended");
    for (i = 0; i < 9; i++) send(ops[i], 1'b0, 1'b0);
    $display("test control and immediate ended");
    send(8'h01, 1'b1, 1'b0);
    send(8'h01, 1'b1, 1'b1);
    send(8'hd6, 1'b1, 1'b1);
    send(8'h01, 1'b0, 1'b1);
    $display("test conditional counts ended");
    for (i = 0; i < 30; i++)
      send(8'($urandom), 1'($urandom), 1'($urandom));
    $display("test random opcodes ended");
    opcode = 8'h9e;
    opValid = 1'b1;
    @(posedge core_clk);
    #1;
    opValid = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    arst_n = 1'b0;
    #1;
    chk_reset();
    @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    send(8'h76, 1'b0, 1'b0);
    $display("test reset mid-run ended");
    complete_run();
  end
endmodule // tb_subtract_control_opcode_decoder
